// file: pkg/lvr_pkg.sv
// Shared constants, types and helper functions of the link interrupt vector router.
package lvr_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_VECTORS = 256;
	localparam int NUM_WORDS   = 8;
	localparam int NUM_LINES   = 4;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PENDING_BASE  = 8'h80;
	localparam logic [7:0] ADDR_PENDING_WORD6 = 8'h98;
	localparam logic [7:0] ADDR_PENDING_WORD7 = 8'h9C;
	localparam logic [7:0] ADDR_ENABLE_BASE   = 8'hA0;
	localparam logic [7:0] ADDR_ENABLE_WORD0  = 8'hA0;
	localparam logic [7:0] ADDR_ENABLE_WORD1  = 8'hA4;
	localparam logic [7:0] ADDR_ENABLE_WORD2  = 8'hA8;
	localparam logic [7:0] ADDR_ENABLE_WORD3  = 8'hAC;
	localparam logic [7:0] ADDR_ROUTE_CFG     = 8'hC0;
	localparam logic [7:0] ADDR_IRQ_STATUS    = 8'hC4;
	localparam logic [7:0] ADDR_IRQ_MASK      = 8'hC8;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WORD       = 32'h00000000;
	localparam logic [1:0]  RST_ROUTE      = 2'h0;
	localparam logic [2:0]  RST_IRQ        = 3'h0;
	localparam int          ROUTE_MODE_LSB = 0;
	localparam int          STAT_MSG_BIT   = 0;
	localparam int          STAT_MASKED_BIT = 1;
	localparam int          STAT_LINE_BIT  = 2;

	// ----------------------------------------------------------------
	// Bus responses and routing modes
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		stripe_by_one_routing  = 2'b00,
		stripe_by_two_routing  = 2'b01,
		stripe_by_four_routing = 2'b10
	} lvr_route_t;

	// Returns the interrupt line of a vector under a routing mode.
	function automatic logic [1:0] lvr_line_of(input logic [7:0] idx, input logic [1:0] mode);
		logic [1:0] line;
		line = idx[7:6];
		if (mode == stripe_by_two_routing) begin
			line = {idx[7], idx[0]};
		end else if (mode == stripe_by_four_routing) begin
			line = idx[1:0];
		end
		return line;
	endfunction

	// Merges write data into an old word under byte strobes.
	function automatic logic [31:0] lvr_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction

endpackage

// file: verilog/lvr_line_map.sv
// Combinational map from pending and enabled vectors onto the four interrupt lines.
`timescale 1ns/10ps
module lvr_line_map
	import lvr_pkg::*;
#(
	parameter int NV = NUM_VECTORS
) (
	input  wire logic [NV-1:0]        pending_bits,
	input  wire logic [NV-1:0]        enable_bits,
	input  wire logic [1:0]           route_mode,
	output logic      [NUM_LINES-1:0] line_active
);

	// Each line is the OR of every enabled, pending vector routed to it.
	always_comb begin
		line_active = '0;
		for (int v = 0; v < NV; v++) begin
			if (pending_bits[v] && enable_bits[v]) begin // see (RULE_11)
				line_active[lvr_line_of(v[7:0], route_mode)] = 1'b1; // see (RULE_02)
			end
		end
	end

endmodule // lvr_line_map

// file: verilog/lvr_router.sv
// Link interrupt vector router with AXI4-Lite register access.
// Operation
// (RULE_01) 256 enable bits, one per vector.
// (RULE_02) Software selects one of three routing patterns.
// (RULE_03) Stripe-by-one: blocks of 64 per line.
// (RULE_04) Stripe-by-two: parity and upper half pick line.
// (RULE_05) Stripe-by-four: line is index modulo four.
// (RULE_06) High controller drives lines four to seven.
// (RULE_07) Word-to-line mapping follows the chosen pattern.
// (RULE_08) Vector bits 255-224 at 0x9C, reset zero.
// (RULE_09) Enable words at 0xA0-0xBC, reset zero.
// (RULE_10) Enable bits 63-32, 95-64 feed lines 0, 1.
// (RULE_11) Line high while routed vector pending and enabled.
// (RULE_12) Link message sets pending until software changes.
`timescale 1ns/10ps
module lvr_router
	import lvr_pkg::*;
#(
	parameter bit HIGH_LINK_CONTROLLER = 1'b0,
	parameter int ADDR_W               = 8
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              msg_valid,
	input  wire logic [7:0]        msg_vector,
	output logic [7:0]             irq_line,
	output logic                   irq
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [NUM_WORDS-1:0][31:0] pending;
	logic [NUM_WORDS-1:0][31:0] enable;
	logic [1:0]                 route_mode;
	logic [2:0]                 irq_status;
	logic [2:0]                 irq_mask;
	logic [NUM_LINES-1:0]       line_active;
	logic [NUM_LINES-1:0]       line_prev;

	// ----------------------------------------------------------------
	// Bus handshake state
	// ----------------------------------------------------------------
	logic              aw_held;
	logic [ADDR_W-1:0] aw_addr;
	logic              w_held;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              aw_hs;
	logic              w_hs;
	logic              wr_fire;
	logic              rd_fire;
	logic              next_aw_held;
	logic              next_w_held;
	logic              next_bvalid;
	logic              next_rvalid;

	// ----------------------------------------------------------------
	// Decoded access
	// ----------------------------------------------------------------
	logic                 wr_pend;
	logic                 wr_enab;
	logic                 wr_route;
	logic                 wr_mask;
	logic                 wr_ok;
	logic [2:0]           wr_word;
	logic [31:0]          rd_value;
	logic                 rd_ok;
	logic                 rd_status;
	logic [2:0]           rd_word;
	logic [2:0]           irq_events;
	logic [2:0]           next_irq_status;
	logic                 msg_masked;

	// Channel handshakes; a write completes once address and data are both held.
	assign aw_hs   = s_axi_awvalid && s_axi_awready;
	assign w_hs    = s_axi_wvalid && s_axi_wready;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// Next values of the hold flags and the response valids.
	assign next_aw_held = (aw_held || aw_hs) && !wr_fire;
	assign next_w_held  = (w_held || w_hs) && !wr_fire;
	assign next_bvalid  = wr_fire || (s_axi_bvalid && !s_axi_bready);
	assign next_rvalid  = rd_fire || (s_axi_rvalid && !s_axi_rready);

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------

	// Address capture; the ready drops while an address is held or a response waits.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held       <= 1'b0;
			aw_addr       <= '0;
			s_axi_awready <= 1'b0;
		end else begin
			aw_held       <= next_aw_held;
			s_axi_awready <= !next_aw_held && !next_bvalid;
			if (aw_hs) begin
				aw_addr <= s_axi_awaddr;
			end
		end
	end

	// Data capture, independent of the address so either may come first.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			w_held       <= 1'b0;
			w_data       <= '0;
			w_strb       <= '0;
			s_axi_wready <= 1'b0;
		end else begin
			w_held       <= next_w_held;
			s_axi_wready <= !next_w_held && !next_bvalid;
			if (w_hs) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Write address decode; unmapped addresses change nothing and get an error response, except those above 0xFF whose low byte is the status offset.
	always_comb begin
		wr_pend  = 1'b0;
		wr_enab  = 1'b0;
		wr_route = 1'b0;
		wr_mask  = 1'b0;
		wr_word  = aw_addr[4:2];
		if (aw_addr[1:0] != 2'b00) begin
			wr_pend = 1'b0;
		end else if (aw_addr[7:5] == ADDR_PENDING_BASE[7:5]) begin
			wr_pend = 1'b1;
		end else if (aw_addr[7:5] == ADDR_ENABLE_BASE[7:5]) begin
			wr_enab = 1'b1;
		end else if (aw_addr[7:0] == ADDR_ROUTE_CFG) begin
			wr_route = 1'b1;
		end else if (aw_addr[7:0] == ADDR_IRQ_MASK) begin
			wr_mask = 1'b1;
		end
		if (ADDR_W > 8 && (aw_addr >> 8) != '0) begin
			wr_pend  = 1'b0;
			wr_enab  = 1'b0;
			wr_route = 1'b0;
			wr_mask  = 1'b0;
		end
	end

	// Status is read-only but a write to it is accepted and ignored.
	assign wr_ok = wr_pend || wr_enab || wr_route || wr_mask || (aw_addr[7:0] == ADDR_IRQ_STATUS);

	// Write response.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			s_axi_bvalid <= next_bvalid;
			if (wr_fire) begin
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Vector registers
	// ----------------------------------------------------------------

	// Pending words; a link message sets its bit, and the set wins over a software write.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pending <= '{default: RST_WORD}; // see (RULE_08)
		end else begin
			for (int i = 0; i < NUM_WORDS; i++) begin
				if (wr_fire && wr_pend && wr_word == i[2:0]) begin
					pending[i] <= lvr_merge(pending[i], w_data, w_strb); // see (RULE_12)
				end
				if (msg_valid && msg_vector[7:5] == i[2:0]) begin
					pending[i][msg_vector[4:0]] <= 1'b1; // see (RULE_12)
				end
			end
		end
	end

	// Enable words, one bit per vector, one enabling and zero masking.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable <= '{default: RST_WORD}; // see (RULE_09)
		end else if (wr_fire && wr_enab) begin
			enable[wr_word] <= lvr_merge(enable[wr_word], w_data, w_strb); // see (RULE_01)
		end
	end

	// Routing method select; the reserved code falls back to blocks of 64.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			route_mode <= RST_ROUTE;
		end else if (wr_fire && wr_route && w_strb[0]) begin
			route_mode <= w_data[ROUTE_MODE_LSB +: 2]; // see (RULE_02)
		end
	end

	// ----------------------------------------------------------------
	// Line routing
	// ----------------------------------------------------------------

	// Pattern decode; word-to-line grouping follows the selected mode.
	lvr_line_map #(
		.NV (NUM_VECTORS)
	) u_line_map (
		.pending_bits (pending), // see (RULE_07)
		.enable_bits  (enable),
		.route_mode   (route_mode), // see (RULE_03) (RULE_04) (RULE_05) (RULE_10)
		.line_active  (line_active)
	);

	// Drives the low or the high group of lines depending on the controller.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_line  <= 8'h00;
			line_prev <= '0;
		end else begin
			line_prev <= line_active;
			if (HIGH_LINK_CONTROLLER) begin
				irq_line <= {line_active, 4'h0}; // see (RULE_06)
			end else begin
				irq_line <= {4'h0, line_active}; // see (RULE_11)
			end
		end
	end

	// ----------------------------------------------------------------
	// Event interrupt
	// ----------------------------------------------------------------

	// A message whose vector is masked is flagged separately.
	assign msg_masked = msg_valid && !enable[msg_vector[7:5]][msg_vector[4:0]];

	// Events: message taken, masked message, a line newly raised.
	assign irq_events[STAT_MSG_BIT]    = msg_valid;
	assign irq_events[STAT_MASKED_BIT] = msg_masked;
	assign irq_events[STAT_LINE_BIT]   = |(line_active & ~line_prev);

	// Sticky status cleared by a read; an event in the same cycle survives.
	assign next_irq_status = (rd_fire && rd_status ? 3'h0 : irq_status) | irq_events;

	// Status, mask and the level interrupt.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_status <= RST_IRQ;
			irq_mask   <= RST_IRQ;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			if (wr_fire && wr_mask && w_strb[0]) begin
				irq_mask <= w_data[2:0];
			end
			irq <= |(next_irq_status & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------

	assign rd_word   = s_axi_araddr[4:2];
	assign rd_status = rd_ok && s_axi_araddr[7:0] == ADDR_IRQ_STATUS;

	// Read decode; unused upper bits read as zero.
	always_comb begin
		rd_value = 32'h00000000;
		rd_ok    = 1'b1;
		if (s_axi_araddr[1:0] != 2'b00) begin
			rd_ok = 1'b0;
		end else if (s_axi_araddr[7:5] == ADDR_PENDING_BASE[7:5]) begin
			rd_value = pending[rd_word];
		end else if (s_axi_araddr[7:5] == ADDR_ENABLE_BASE[7:5]) begin
			rd_value = enable[rd_word];
		end else if (s_axi_araddr[7:0] == ADDR_ROUTE_CFG) begin
			rd_value[ROUTE_MODE_LSB +: 2] = route_mode;
		end else if (s_axi_araddr[7:0] == ADDR_IRQ_STATUS) begin
			rd_value[2:0] = irq_status;
		end else if (s_axi_araddr[7:0] == ADDR_IRQ_MASK) begin
			rd_value[2:0] = irq_mask;
		end else begin
			rd_ok = 1'b0;
		end
		if (ADDR_W > 8 && (s_axi_araddr >> 8) != '0) begin
			rd_ok    = 1'b0;
			rd_value = 32'h00000000;
		end
	end

	// Read response, one outstanding read at a time.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			if (rd_fire) begin
				s_axi_rdata <= rd_ok ? rd_value : 32'h00000000;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

endmodule // lvr_router

// file: bench/lvr_msg_source.sv
// Link-side model that posts interrupt messages into the router.
`timescale 1ns/10ps
module lvr_msg_source (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       send,
	input  wire logic [7:0] vec,
	output logic            msg_valid,
	output logic [7:0]      msg_vector
);
	// Posts one single-cycle message per request; idle vector lines toggle so stale data never looks valid.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			msg_valid  <= 1'b0;
			msg_vector <= 8'h00;
		end else begin
			msg_valid  <= send;
			msg_vector <= send ? vec : ~msg_vector;
		end
	end
endmodule // lvr_msg_source

// file: bench/lvr_router_asserts.sv
// Concurrent checks on the router's register bus and interrupt lines.
`timescale 1ns/10ps
module lvr_router_asserts
	import lvr_pkg::*;
#(
	parameter bit HIGH_LINK_CONTROLLER = 1'b0
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        msg_valid,
	input wire logic [7:0]  irq_line
);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Both write channels taken at one edge, and a read address taken.
	sequence s_write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
		else $error("write response late or missing");
	a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
		else $error("read data late or missing");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
		else $error("error read returned data");
	a_half_idle: assert property ((HIGH_LINK_CONTROLLER ? irq_line[3:0] : irq_line[7:4]) == 4'h0)
		else $error("unused line half driven");
	a_line_cause: assert property (!$stable(irq_line) |->
		$past(msg_valid, 2) || $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2))
		else $error("line changed without message or write");
endmodule // lvr_router_asserts

bind lvr_router lvr_router_asserts #(.HIGH_LINK_CONTROLLER(HIGH_LINK_CONTROLLER)) u_lvr_router_asserts (
	.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .msg_valid(msg_valid), .irq_line(irq_line)
);

// file: bench/lvr_router_tb_top.sv
// Self-checking bench of the link interrupt vector router.
`timescale 1ns/10ps
module lvr_router_tb_top
	import lvr_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals, model state and clock
	// ----------------------------------------------------------------
	logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, send = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, vec = 8'h00, irq_line, msg_vector;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, msg_valid, irq;
	int          bad_count = 0, checked = 0, cycles = 0, seed = 99105;
	int          pend[8], en[8];
	int          edges[8] = '{0, 63, 64, 127, 128, 191, 192, 255};

	always #5 clk = ~clk;

	lvr_router u_lvr_router (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .msg_valid(msg_valid),
		.msg_vector(msg_vector), .irq_line(irq_line), .irq(irq));
	lvr_msg_source u_lvr_msg_source (.clk(clk), .rst(rst), .send(send), .vec(vec),
		.msg_valid(msg_valid), .msg_vector(msg_vector));

	// Cuts a hung run short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("comparisons=%0d mismatches=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Offers address and data together, releases each on its own handshake, then takes the response late.
	task automatic mw(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		fork
			begin do @(posedge clk); while (awready !== 1'b1); awvalid <= 1'b0; end
			begin do @(posedge clk); while (wready !== 1'b1); wvalid <= 1'b0; end
		join
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b1;
		@(posedge clk);
		chk(32'(bresp), (a >= 8'h80 && a <= ADDR_IRQ_MASK && a[1:0] == 2'b00) ? 32'(RESP_OKAY) : 32'(RESP_SLVERR));
		bready <= 1'b0;
		if (a >= 8'h80 && a < 8'hA0) pend[(a - 8'h80) / 4] = d;
		else if (a >= 8'hA0 && a < 8'hC0) en[(a - 8'hA0) / 4] = d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a; arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b1;
		@(posedge clk);
		d = rdata; r = rresp; rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, exp);
	endtask
	// Posts one message and records it in the model.
	task automatic msg(input int v);
		send <= 1'b1; vec <= 8'(v);
		@(posedge clk);
		send <= 1'b0;
		pend[v / 32][v % 32] = 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// Expected line levels of the model under a routing mode.
	function automatic logic [31:0] exp_lines(input int mode);
		logic [31:0] l;
		int          ln;
		l = 32'h00000000;
		for (int v = 0; v < 256; v++) begin
			ln = mode == 1 ? (v / 128) * 2 + v % 2 : mode == 2 ? v % 4 : v / 64;
			if (pend[v / 32][v % 32] && en[v / 32][v % 32]) l[ln] = 1'b1;
		end
		return l;
	endfunction
	task automatic lchk(input int m);
		@(posedge clk);
		chk({24'h000000, irq_line}, exp_lines(m));
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          v;
		for (int i = 0; i < 8; i++) begin pend[i] = 0; en[i] = 0; end
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rchk(8'h80 + 8'(i * 4), 32'h00000000);
			rchk(8'hA0 + 8'(i * 4), 32'h00000000);
		end
		rd(8'hFC, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		chk(d, 32'h00000000);
		mw(8'hFC, 32'hFFFFFFFF);
		mw(8'hA2, 32'hFFFFFFFF);
		rchk(ADDR_ENABLE_WORD0, 32'h00000000);
		for (int i = 0; i < 5; i++) begin
			d = $random(seed);
			mw(8'h9C + 8'(i * 4), d);
			rchk(8'h9C + 8'(i * 4), d);
		end
		for (int m = 0; m < 4; m++) begin
			mw(ADDR_ROUTE_CFG, m);
			rchk(ADDR_ROUTE_CFG, m);
			for (int i = 0; i < 8; i++) mw(8'h80 + 8'(i * 4), 32'h00000000);
			for (int i = 0; i < 8; i++) mw(8'hA0 + 8'(i * 4), 32'hFFFFFFFF);
			for (int k = 0; k < 12; k++) begin
				v = k < 8 ? edges[k] : $random(seed) & 255;
				msg(v);
				lchk(m);
				mw(8'h80 + 8'(v / 32 * 4), 32'h00000000);
				lchk(m);
			end
		end
		mw(ADDR_ROUTE_CFG, 0);
		for (int i = 0; i < 4; i++) mw(8'hA0 + 8'(i * 4), $random(seed));
		for (int k = 0; k < 16; k++) begin
			v = $random(seed) & 127;
			msg(v);
			lchk(0);
			rchk(8'h80 + 8'(v / 32 * 4), pend[v / 32]);
		end
		rd(ADDR_IRQ_STATUS, d, r);
		mw(ADDR_IRQ_MASK, 32'h00000007);
		mw(ADDR_ENABLE_WORD0, 32'h00000000);
		msg(5);
		chk(32'(irq), 32'h00000001);
		rchk(ADDR_IRQ_STATUS, 32'h00000003);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h00000000);
		mw(ADDR_IRQ_MASK, 32'h00000000);
		msg(5);
		chk(32'(irq), 32'h00000000);
		rchk(ADDR_IRQ_STATUS, 32'h00000003);
		report_and_stop();
	end
endmodule // lvr_router_tb_top
